/* pkg/deac_defs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef DEAC_DEFS_SVH
`define DEAC_DEFS_SVH
// wishbone byte offsets
`define DEAC_ADR_W 5
`define DEAC_OFS_ADDR 5'h00
`define DEAC_OFS_DATA 5'h04
`define DEAC_OFS_CTRL 5'h08
`define DEAC_OFS_UNLOCK 5'h0C
`define DEAC_OFS_FLAGS 5'h10
// control/status field positions
`define DEAC_B_MSS 7
`define DEAC_B_CSS 6
`define DEAC_B_WRITE_ERROR_FLAG 3
`define DEAC_B_WRITE_ALLOW 2
`define DEAC_B_WR 1
`define DEAC_B_RD 0
// completion flag position in the flag register
`define DEAC_B_DONE 4
// reset values
`define DEAC_BYTE_RST 8'h00
`define DEAC_WORD_ZERO 32'h0000_0000
// unlock keys and erased byte value
`define DEAC_KEY_1 8'h55
`define DEAC_KEY_2 8'hAA
`define DEAC_ERASED 8'hFF
// self-timed write duration
`define DEAC_CLK_PERIOD_NS 5
`define DEAC_WRITE_TIME_NS 4000000
`define DEAC_WRITE_CYCLES (`DEAC_WRITE_TIME_NS / `DEAC_CLK_PERIOD_NS)
`endif

/* pkg/deac_pkg.sv */
// types shared by the data eeprom access control block
`include "deac_defs.svh"
package deac_pkg;
  // write sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASE = 2'b01,
    ST_PROG = 2'b10
  } deac_state_t;
  // selected memory space
  typedef enum logic [1:0] {
    SP_EEPROM = 2'b00,
    SP_PROGRAM = 2'b01,
    SP_CONFIG = 2'b10
  } deac_space_t;
  // wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [`DEAC_ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } deac_wb_req_t;
  // wishbone answer to the master
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } deac_wb_rsp_t;
  // request towards program or configuration space
  typedef struct packed {
    logic valid;
    logic we;
    deac_space_t space;
    logic [7:0] addr;
    logic [7:0] data;
  } deac_ext_req_t;
endpackage : deac_pkg

/* verilog/deac_mem.sv */
// byte array holding the data eeprom contents
`timescale 1ns/1ps
`default_nettype none
module deac_mem #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 8
) (
  // clock and freeze
  input wire logic clk_i,
  input wire logic ce_i,
  // single port
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] cells [0:(1<<AW)-1]; // no reset: contents are nonvolatile

  // write port
  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      cells[addr_i] <= wdata_i;
    end
  end

  // registered read, following the address on every clock-enabled cycle
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      rdata_o <= cells[addr_i];
    end
  end
endmodule : deac_mem
`default_nettype wire

/* verilog/deac_ctrl.sv */
// data eeprom access control with wishbone register port
// Overview of operation
// - select clear: eeprom, set: program memory
// - config select overrides memory space select on writes; a read start with memory space select set is ignored
// - write starts only while write allow set
// - power-up clears write allow
// - error flag set on start, cleared at finish
// - error flag left set stays readable
// - software sets write start, never clears it
// - completion sets done flag; software clears it
// - read/write start bits cleared by hardware
// - read start ignored with program memory selected
// - unlock port stores nothing, reads zero
// - address register spans 256 byte locations
// - data register holds the byte transferred
// - eeprom byte write erases location before programming
// - self-timer sets write duration and completion
// - writes accepted only after unlock sequence
// - array reached only through the registers
`timescale 1ns/1ps
`default_nettype none
`include "deac_defs.svh"
module deac_ctrl #(
  parameter int unsigned WRITE_CYCLES = `DEAC_WRITE_CYCLES
) (
  // clock, freeze and resets
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic rst_i,
  input wire logic warm_rst_i,
  // wishbone slave
  input wire deac_pkg::deac_wb_req_t wb_req_i,
  output var deac_pkg::deac_wb_rsp_t wb_rsp_o,
  // program and configuration space
  output var deac_pkg::deac_ext_req_t ext_req_o,
  input wire logic [7:0] ext_rdata_i,
  // completion flag
  output logic nvm_done_flag_o
);
  import deac_pkg::*;

  localparam int unsigned ERASE_CYCLES = WRITE_CYCLES / 2;
  localparam int unsigned PROG_CYCLES = WRITE_CYCLES - ERASE_CYCLES;
  localparam int unsigned CNT_W = $clog2(WRITE_CYCLES + 1);

  // space chosen by the two select bits
  function automatic deac_space_t space_of(input logic mss,
                                           input logic css);
    if (css) begin
      return SP_CONFIG;
    end
    return mss ? SP_PROGRAM : SP_EEPROM;
  endfunction : space_of

  logic [7:0] nv_byte_address; // byte location, 00h..FFh
  logic [7:0] nv_byte_data; // byte to write or byte read
  logic memory_space_select;
  logic config_space_select;
  logic write_allow;
  logic write_error_flag;
  logic wr_bit; // write start, set-only from software
  logic rd_bit; // read start, one cycle
  logic [1:0] unlock_stage; // 0 none, 1 got first key, 2 armed
  deac_state_t state;
  logic [CNT_W-1:0] timer; // self-timer for current phase
  logic [7:0] lat_addr; // address captured at write start
  logic [7:0] lat_data; // data captured at write start
  deac_space_t lat_space;
  logic rd_cfg; // read in flight is from config space
  logic [7:0] mem_rdata;

  // bus decode, all gated by the clock enable
  logic acc, acc_wr, acc_rd;
  logic [7:0] wdat;
  logic wr_addr, wr_data, wr_ctrl, wr_unlock, wr_flags;
  assign acc = ce_i && wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  assign acc_wr = acc && wb_req_i.we && wb_req_i.sel[0];
  assign acc_rd = acc && !wb_req_i.we;
  assign wdat = wb_req_i.dat[7:0];
  assign wr_addr = acc_wr && wb_req_i.adr == `DEAC_OFS_ADDR;
  assign wr_data = acc_wr && wb_req_i.adr == `DEAC_OFS_DATA;
  assign wr_ctrl = acc_wr && wb_req_i.adr == `DEAC_OFS_CTRL;
  assign wr_unlock = acc_wr && wb_req_i.adr == `DEAC_OFS_UNLOCK;
  assign wr_flags = acc_wr && wb_req_i.adr == `DEAC_OFS_FLAGS;

  // launch and completion events
  logic wr_try, start, bad_try, rd_try, rd_ok, erase_end, finish;
  logic mem_we;
  logic [7:0] mem_wdata;
  assign wr_try = wr_ctrl && wdat[`DEAC_B_WR] && !wr_bit;
  // armed and allowed, else the set attempt is dropped
  assign start = wr_try && unlock_stage == 2'd2 && write_allow
                 && state == ST_IDLE;
  assign bad_try = wr_try && !start;
  assign rd_try = wr_ctrl && wdat[`DEAC_B_RD];
  // program memory reads go through table reads instead
  assign rd_ok = rd_try && !wdat[`DEAC_B_MSS] && !rd_bit
                 && state == ST_IDLE;
  assign erase_end = ce_i && state == ST_ERASE && timer == '0;
  assign finish = ce_i && state == ST_PROG && timer == '0;
  // erase writes all ones, then the new byte goes in
  assign mem_we = (erase_end || finish) && lat_space == SP_EEPROM;
  assign mem_wdata = (state == ST_ERASE) ? `DEAC_ERASED : lat_data;

  // the array is only visible through this port
  deac_mem #(
    .AW(8),
    .DW(8)
  ) u_mem (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .we_i(mem_we),
    .addr_i((state == ST_IDLE) ? nv_byte_address : lat_addr),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
  );

  // address register
  always_ff @(posedge clk_i) begin
    if (rst_i || warm_rst_i) begin
      nv_byte_address <= `DEAC_BYTE_RST;
    end else if (wr_addr) begin
      nv_byte_address <= wdat;
    end
  end

  // data register: read load wins over a bus write
  always_ff @(posedge clk_i) begin
    if (rst_i || warm_rst_i) begin
      nv_byte_data <= `DEAC_BYTE_RST;
    end else if (ce_i && rd_bit) begin
      nv_byte_data <= rd_cfg ? ext_rdata_i : mem_rdata;
    end else if (wr_data) begin
      nv_byte_data <= wdat;
    end
  end

  // space selects and write allow
  always_ff @(posedge clk_i) begin
    if (rst_i || warm_rst_i) begin
      memory_space_select <= 1'b0;
      config_space_select <= 1'b0;
      write_allow <= 1'b0;
    end else if (wr_ctrl) begin
      memory_space_select <= wdat[`DEAC_B_MSS];
      config_space_select <= wdat[`DEAC_B_CSS];
      write_allow <= wdat[`DEAC_B_WRITE_ALLOW];
    end
  end

  // error flag survives a warm reset, set if it cut a write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      write_error_flag <= 1'b0;
    end else if (warm_rst_i) begin
      if (state != ST_IDLE) begin
        write_error_flag <= 1'b1;
      end
    end else if (start || bad_try) begin
      write_error_flag <= 1'b1;
    end else if (finish) begin
      write_error_flag <= 1'b0;
    end else if (wr_ctrl) begin
      write_error_flag <= wdat[`DEAC_B_WRITE_ERROR_FLAG];
    end
  end

  // unlock keys: any other bus write with sel[0] set breaks the sequence
  always_ff @(posedge clk_i) begin
    if (rst_i || warm_rst_i) begin
      unlock_stage <= 2'd0;
    end else if (wr_unlock) begin
      if (wdat == `DEAC_KEY_1) begin
        unlock_stage <= 2'd1;
      end else if (wdat == `DEAC_KEY_2 && unlock_stage == 2'd1) begin
        unlock_stage <= 2'd2;
      end else begin
        unlock_stage <= 2'd0;
      end
    end else if (acc_wr) begin
      unlock_stage <= 2'd0;
    end
  end

  // write start bit: only hardware clears it
  always_ff @(posedge clk_i) begin
    if (rst_i || warm_rst_i) begin
      wr_bit <= 1'b0;
    end else if (start) begin
      wr_bit <= 1'b1;
    end else if (finish) begin
      wr_bit <= 1'b0;
    end
  end

  // read start bit lives one cycle while data settles
  always_ff @(posedge clk_i) begin
    if (rst_i || warm_rst_i) begin
      rd_bit <= 1'b0;
      rd_cfg <= 1'b0;
    end else if (ce_i) begin
      if (rd_ok) begin
        rd_bit <= 1'b1;
        rd_cfg <= wdat[`DEAC_B_CSS];
      end else begin
        rd_bit <= 1'b0;
      end
    end
  end

  // write sequencer: erase phase then program phase
  always_ff @(posedge clk_i) begin
    if (rst_i || warm_rst_i) begin
      state <= ST_IDLE;
      timer <= '0;
    end else if (ce_i) begin
      unique case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_ERASE;
            timer <= CNT_W'(ERASE_CYCLES - 1);
          end
        end
        ST_ERASE: begin
          if (timer == '0) begin
            state <= ST_PROG;
            timer <= CNT_W'(PROG_CYCLES - 1);
          end else begin
            timer <= timer - 1'b1;
          end
        end
        ST_PROG: begin
          if (timer == '0) begin
            state <= ST_IDLE;
          end else begin
            timer <= timer - 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE; // unused code, recover
        end
      endcase
    end
  end

  // capture target at start so software edits cannot disturb it
  always_ff @(posedge clk_i) begin
    if (rst_i || warm_rst_i) begin
      lat_addr <= `DEAC_BYTE_RST;
      lat_data <= `DEAC_BYTE_RST;
      lat_space <= SP_EEPROM;
    end else if (start) begin
      lat_addr <= nv_byte_address;
      lat_data <= nv_byte_data;
      lat_space <= space_of(memory_space_select, config_space_select);
    end
  end

  // completion flag: the set wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i || warm_rst_i) begin
      nvm_done_flag_o <= 1'b0;
    end else if (finish) begin
      nvm_done_flag_o <= 1'b1;
    end else if (wr_flags) begin
      nvm_done_flag_o <= wdat[`DEAC_B_DONE];
    end
  end

  // one-cycle request towards program or config space
  always_ff @(posedge clk_i) begin
    if (rst_i || warm_rst_i) begin
      ext_req_o <= '0;
    end else if (ce_i) begin
      ext_req_o <= '0;
      if (start && space_of(memory_space_select,
                            config_space_select) != SP_EEPROM) begin
        ext_req_o.valid <= 1'b1;
        ext_req_o.we <= 1'b1;
        ext_req_o.space <= space_of(memory_space_select,
                                    config_space_select);
        ext_req_o.addr <= nv_byte_address;
        ext_req_o.data <= nv_byte_data;
      end else if (rd_ok && wdat[`DEAC_B_CSS]) begin
        ext_req_o.valid <= 1'b1;
        ext_req_o.space <= SP_CONFIG;
        ext_req_o.addr <= nv_byte_address;
      end
    end
  end

  // wishbone answer one cycle after the request, zero if unmapped
  always_ff @(posedge clk_i) begin
    if (rst_i || warm_rst_i) begin
      wb_rsp_o <= '0;
    end else if (ce_i) begin
      wb_rsp_o.ack <= acc;
      if (acc_rd) begin
        wb_rsp_o.dat <= `DEAC_WORD_ZERO;
        unique case (wb_req_i.adr)
          `DEAC_OFS_ADDR: wb_rsp_o.dat[7:0] <= nv_byte_address;
          `DEAC_OFS_DATA: wb_rsp_o.dat[7:0] <= nv_byte_data;
          `DEAC_OFS_CTRL: wb_rsp_o.dat[7:0] <= {memory_space_select,
            config_space_select, 2'b00, write_error_flag, write_allow,
            wr_bit, rd_bit};
          `DEAC_OFS_FLAGS: wb_rsp_o.dat[`DEAC_B_DONE] <= nvm_done_flag_o;
          default: wb_rsp_o.dat[7:0] <= `DEAC_BYTE_RST;
        endcase
      end
    end
  end

  // helper: cycles spent in the current write
  logic [CNT_W-1:0] busy_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i || warm_rst_i || start) begin
      busy_cnt <= '0;
    end else if (ce_i && state != ST_IDLE) begin
      busy_cnt <= busy_cnt + 1'b1;
    end
  end

  property p_start_armed;
    @(posedge clk_i) disable iff (rst_i || warm_rst_i)
    wr_try && (unlock_stage != 2'd2 || !write_allow) |=> !wr_bit;
  endproperty
  a_start_armed: assert property (p_start_armed)
    else $error("write started without unlock or write allow");

  property p_write_error_flag_set;
    @(posedge clk_i) disable iff (rst_i || warm_rst_i)
    start |=> write_error_flag && wr_bit && state == ST_ERASE;
  endproperty
  a_write_error_flag_set: assert property (p_write_error_flag_set)
    else $error("start did not set error flag and write start");

  property p_finish_flags;
    @(posedge clk_i) disable iff (rst_i || warm_rst_i)
    finish |=> nvm_done_flag_o && !wr_bit && !write_error_flag;
  endproperty
  a_finish_flags: assert property (p_finish_flags)
    else $error("completion flags wrong after write end");

  property p_wr_sticky;
    @(posedge clk_i) disable iff (rst_i || warm_rst_i)
    wr_bit && !finish |=> wr_bit;
  endproperty
  a_wr_sticky: assert property (p_wr_sticky)
    else $error("write start cleared before completion");

  property p_rd_ignored;
    @(posedge clk_i) disable iff (rst_i || warm_rst_i)
    rd_try && wdat[`DEAC_B_MSS] && !rd_bit |=> !rd_bit;
  endproperty
  a_rd_ignored: assert property (p_rd_ignored)
    else $error("read start accepted with program memory selected");

  sequence s_rd_launch;
    rd_ok && !wdat[`DEAC_B_CSS];
  endsequence
  sequence s_rd_load;
    ##1 (rd_bit && ce_i) ##1 (!rd_bit && nv_byte_data == $past(mem_rdata));
  endsequence
  property p_rd_load;
    @(posedge clk_i) disable iff (rst_i || warm_rst_i)
    s_rd_launch |-> s_rd_load;
  endproperty
  a_rd_load: assert property (p_rd_load)
    else $error("read did not load data register in time");

  property p_unlock_zero;
    @(posedge clk_i) disable iff (rst_i || warm_rst_i)
    acc_rd && wb_req_i.adr == `DEAC_OFS_UNLOCK
      |=> wb_rsp_o.ack && wb_rsp_o.dat == `DEAC_WORD_ZERO;
  endproperty
  a_unlock_zero: assert property (p_unlock_zero)
    else $error("unlock port read returned nonzero");

  property p_erase_first;
    @(posedge clk_i) disable iff (rst_i || warm_rst_i)
    erase_end && lat_space == SP_EEPROM
      |-> mem_we && mem_wdata == `DEAC_ERASED;
  endproperty
  a_erase_first: assert property (p_erase_first)
    else $error("erase phase did not blank the location");

  property p_timed;
    @(posedge clk_i) disable iff (rst_i || warm_rst_i)
    finish |-> busy_cnt == CNT_W'(WRITE_CYCLES - 1);
  endproperty
  a_timed: assert property (p_timed)
    else $error("write finished at wrong self-timer count");

  property p_write_allow_por;
    @(posedge clk_i) disable iff (warm_rst_i)
    $fell(rst_i) |-> !write_allow && !wr_bit;
  endproperty
  a_write_allow_por: assert property (p_write_allow_por)
    else $error("write allow not clear after power-up reset");

  property p_space_cfg;
    @(posedge clk_i) disable iff (rst_i || warm_rst_i)
    start && config_space_select
      |=> ext_req_o.valid && ext_req_o.space == SP_CONFIG;
  endproperty
  a_space_cfg: assert property (p_space_cfg)
    else $error("config select did not route the write");

  property p_space_ee;
    @(posedge clk_i) disable iff (rst_i || warm_rst_i)
    start && !config_space_select && !memory_space_select
      |=> !ext_req_o.valid;
  endproperty
  a_space_ee: assert property (p_space_ee)
    else $error("eeprom write leaked to program space");
endmodule : deac_ctrl
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the data eeprom access control block
`timescale 1ns/1ps
`default_nettype none
`include "deac_defs.svh"
module tb_top;
  import deac_pkg::*;
  localparam int WC = 20; // shortened self-timer for simulation
  // stimulus and observed signals
  logic clk_i = 1'b0;
  logic ce_i = 1'b1; // freeze, dropped once mid-write
  logic rst_i = 1'b1;
  logic warm_rst_i = 1'b0;
  deac_wb_req_t wb_req_i = '0;
  deac_wb_rsp_t wb_rsp_o;
  deac_ext_req_t ext_req_o;
  logic [7:0] ext_rdata_i = 8'h3C;
  logic nvm_done_flag_o;
  int fails = 0;
  int tests_run = 0;
  int cyc_n = 0; // free cycle count for timing checks
  int ext_cnt = 0; // number of far-space requests seen
  deac_ext_req_t ext_last = '0; // last far-space request
  logic [7:0] q;
  int t0;
  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;
  // device under test
  deac_ctrl #(.WRITE_CYCLES(WC)) deac_ctrl_inst (
    .clk_i(clk_i), .ce_i(ce_i), .rst_i(rst_i), .warm_rst_i(warm_rst_i),
    .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .ext_req_o(ext_req_o),
    .ext_rdata_i(ext_rdata_i), .nvm_done_flag_o(nvm_done_flag_o));
  // capture one-cycle far-space pulses, they stand only one cycle
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (ext_req_o.valid === 1'b1) begin
      ext_cnt <= ext_cnt + 1;
      ext_last <= ext_req_o;
    end
  end
  // compare and count
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // verdict, the single exit of the run
  task automatic test_done();
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  // one classic wishbone cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [4:0] adr,
                    input logic [7:0] d, input logic [3:0] sel,
                    output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel,
                  dat: {24'h000000, d}};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_rsp_o.ack !== 1'b1 && n < 50);
    rd = wb_rsp_o.dat[7:0];
    if (n >= 50) begin
      fails++;
      $display("MISMATCH ack expected 1 seen timeout");
      test_done();
    end
    wb_req_i <= '0;
  endtask : wb
  task automatic wr(input logic [4:0] adr, input logic [7:0] d);
    logic [7:0] x;
    wb(1'b1, adr, d, 4'hF, x);
  endtask : wr
  task automatic rd_chk(input string what, input logic [4:0] adr,
                        input logic [7:0] exp);
    logic [7:0] x;
    wb(1'b0, adr, 8'h00, 4'hF, x);
    check(what, {24'h000000, x}, {24'h000000, exp});
  endtask : rd_chk
  // the two key writes that arm a start
  task automatic unlock();
    wr(`DEAC_OFS_UNLOCK, `DEAC_KEY_1);
    wr(`DEAC_OFS_UNLOCK, `DEAC_KEY_2);
  endtask : unlock
  // poll until write start drops, bounded
  task automatic wait_idle();
    logic [7:0] x;
    int n;
    n = 0;
    do begin
      wb(1'b0, `DEAC_OFS_CTRL, 8'h00, 4'hF, x);
      n++;
    end while (x[`DEAC_B_WR] !== 1'b0 && n < 100);
    if (n >= 100) begin
      fails++;
      $display("MISMATCH write end expected done seen timeout");
      test_done();
    end
  endtask : wait_idle
  // full unlocked byte write into the eeprom
  task automatic ee_write(input logic [7:0] a, input logic [7:0] d);
    wr(`DEAC_OFS_ADDR, a);
    wr(`DEAC_OFS_DATA, d);
    wr(`DEAC_OFS_CTRL, 8'h04);
    unlock();
    wr(`DEAC_OFS_CTRL, 8'h06);
  endtask : ee_write
  // start a read and check the data register
  task automatic ee_read(input string what, input logic [7:0] a,
                         input logic [7:0] exp);
    wr(`DEAC_OFS_ADDR, a);
    wr(`DEAC_OFS_DATA, 8'h00); // clobber so a missed load shows
    wr(`DEAC_OFS_CTRL, 8'h01);
    rd_chk(what, `DEAC_OFS_DATA, exp);
  endtask : ee_read
  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values and plain register access
    rd_chk("ctrl reset", `DEAC_OFS_CTRL, 8'h00);
    rd_chk("unlock read", `DEAC_OFS_UNLOCK, 8'h00);
    wr(`DEAC_OFS_UNLOCK, 8'h55);
    rd_chk("unlock no store", `DEAC_OFS_UNLOCK, 8'h00);
    wr(`DEAC_OFS_ADDR, 8'hFF);
    rd_chk("addr top", `DEAC_OFS_ADDR, 8'hFF);
    wr(`DEAC_OFS_DATA, 8'h96);
    rd_chk("data reg", `DEAC_OFS_DATA, 8'h96);
    wb(1'b1, `DEAC_OFS_DATA, 8'h11, 4'hE, q);
    rd_chk("data sel0 low", `DEAC_OFS_DATA, 8'h96);
    rd_chk("unmapped", 5'h14, 8'h00);
    $display("test registers done");
    // improper starts: no keys, wrong order, broken, no allow
    wr(`DEAC_OFS_CTRL, 8'h04);
    wr(`DEAC_OFS_CTRL, 8'h06);
    rd_chk("start no keys", `DEAC_OFS_CTRL, 8'h0C);
    wr(`DEAC_OFS_CTRL, 8'h04);
    wr(`DEAC_OFS_UNLOCK, 8'hAA);
    wr(`DEAC_OFS_UNLOCK, 8'h55);
    wr(`DEAC_OFS_CTRL, 8'h06);
    rd_chk("keys reversed", `DEAC_OFS_CTRL, 8'h0C);
    wr(`DEAC_OFS_CTRL, 8'h04);
    unlock();
    wr(`DEAC_OFS_ADDR, 8'h20);
    wr(`DEAC_OFS_CTRL, 8'h06);
    rd_chk("keys broken", `DEAC_OFS_CTRL, 8'h0C);
    wr(`DEAC_OFS_CTRL, 8'h00);
    unlock();
    wr(`DEAC_OFS_CTRL, 8'h02);
    rd_chk("no allow", `DEAC_OFS_CTRL, 8'h08);
    check("no done", {31'h0, nvm_done_flag_o}, 32'h0);
    $display("test guards done");
    // proper write, self-timed, flags
    ee_write(8'hFF, 8'hA5);
    t0 = cyc_n;
    rd_chk("busy ctrl", `DEAC_OFS_CTRL, 8'h0E);
    // freeze longer than a whole write: nothing may advance
    ce_i <= 1'b0;
    repeat (2 * WC) @(posedge clk_i);
    ce_i <= 1'b1;
    rd_chk("frozen busy", `DEAC_OFS_CTRL, 8'h0E);
    wr(`DEAC_OFS_CTRL, 8'h0C);
    rd_chk("start sticks", `DEAC_OFS_CTRL, 8'h0E);
    wait_idle();
    check("timer span", {31'h0, (cyc_n - t0) >= WC}, 32'h1);
    rd_chk("write end ctrl", `DEAC_OFS_CTRL, 8'h04);
    check("done port", {31'h0, nvm_done_flag_o}, 32'h1);
    rd_chk("done reg", `DEAC_OFS_FLAGS, 8'h10);
    rd_chk("done kept", `DEAC_OFS_FLAGS, 8'h10);
    wr(`DEAC_OFS_FLAGS, 8'h00);
    check("done clear", {31'h0, nvm_done_flag_o}, 32'h0);
    ee_read("read back", 8'hFF, 8'hA5);
    rd_chk("read end", `DEAC_OFS_CTRL, 8'h00);
    ee_write(8'hFF, 8'h5A);
    wait_idle();
    ee_read("erase first", 8'hFF, 8'h5A);
    ee_write(8'h00, 8'h3E);
    wait_idle();
    ee_read("low byte", 8'h00, 8'h3E);
    ee_read("top intact", 8'hFF, 8'h5A);
    $display("test eeprom done");
    // program and configuration spaces
    t0 = ext_cnt;
    wr(`DEAC_OFS_DATA, 8'h77);
    wr(`DEAC_OFS_CTRL, 8'h81);
    rd_chk("prog read ignored", `DEAC_OFS_CTRL, 8'h80);
    rd_chk("prog read data", `DEAC_OFS_DATA, 8'h77);
    check("prog read no req", ext_cnt - t0, 32'h0);
    wr(`DEAC_OFS_CTRL, 8'h84);
    unlock();
    wr(`DEAC_OFS_CTRL, 8'h86);
    wait_idle();
    check("prog write req", ext_cnt - t0, 32'h1);
    check("prog space", {30'h0, ext_last.space}, {30'h0, SP_PROGRAM});
    check("prog we", {31'h0, ext_last.we}, 32'h1);
    wr(`DEAC_OFS_CTRL, 8'hC4);
    unlock();
    wr(`DEAC_OFS_CTRL, 8'hC6);
    wait_idle();
    check("cfg override", {30'h0, ext_last.space}, {30'h0, SP_CONFIG});
    wr(`DEAC_OFS_CTRL, 8'h41);
    repeat (4) @(posedge clk_i);
    check("cfg read req", ext_cnt - t0, 32'h3);
    check("cfg read we", {31'h0, ext_last.we}, 32'h0);
    rd_chk("cfg read data", `DEAC_OFS_DATA, 8'h3C);
    $display("test spaces done");
    // a warm reset cutting a write short leaves the error visible
    wr(`DEAC_OFS_FLAGS, 8'h00);
    ee_write(8'h40, 8'h12);
    @(posedge clk_i);
    warm_rst_i <= 1'b1;
    @(posedge clk_i);
    warm_rst_i <= 1'b0;
    rd_chk("warm cut", `DEAC_OFS_CTRL, 8'h08);
    check("warm no done", {31'h0, nvm_done_flag_o}, 32'h0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("por clears", `DEAC_OFS_CTRL, 8'h00);
    $display("test resets done");
    test_done();
  end
  // overall bound on the run
  initial begin
    #200000;
    fails++;
    $display("MISMATCH run expected end seen timeout");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
